// File: pkg/tlbd_pkg.sv
package tlbd_pkg;

	// register indices on the register port
	localparam logic [1:0] TLBD_IDX_CONTROL = 2'h0;
	localparam logic [1:0] TLBD_IDX_BASE = 2'h1;
	localparam logic [1:0] TLBD_IDX_EXT_TOP = 2'h2;
	localparam logic [1:0] TLBD_IDX_FILL = 2'h3;

	// control register bit positions
	localparam int TLBD_CTL_GO = 0;
	localparam int TLBD_CTL_TCAP_EN = 1;
	localparam int TLBD_CTL_TCAP_MAN = 2;
	localparam int TLBD_CTL_RUNNING = 3;
	localparam int TLBD_CTL_BUF_FULL = 4;
	localparam int TLBD_CTL_OVERRUN = 5;
	localparam int TLBD_CTL_SWAP_IRQ = 6;

	// extension and top station register fields
	localparam int TLBD_EXT_LSB = 0;
	localparam int TLBD_TOP_LSB = 8;

	// values after reset
	localparam logic [15:0] TLBD_RST_WORD = 16'h0000;
	localparam logic [7:0] TLBD_RST_BYTE = 8'h00;
	localparam logic [7:0] TLBD_RST_SLOT = 8'h00;

	// widths of the memory side
	localparam int TLBD_ADDR_W = 24;
	localparam int TLBD_DATA_W = 16;

	// bytes per sample, a single word-aligned transfer
	localparam logic [7:0] TLBD_SAMPLE_BYTES = 8'h02;

	// three components per station
	localparam logic [1:0] TLBD_COMPONENTS = 2'h3;

	// clock period in ns, for the bench
	localparam int TLBD_CLK_PERIOD_NS = 8;

	typedef enum logic {
		TLBD_DMA_IDLE,
		TLBD_DMA_BUSY
	} tlbd_dma_e;

endpackage

// File: rtl/tlbd_addr_calc.sv
module tlbd_addr_calc
	import tlbd_pkg::*;
(
	input wire logic [7:0] fill_bytes,
	input wire logic [15:0] base,
	input wire logic [7:0] ext,
	input wire logic [3:0] station,
	input wire logic [1:0] component,
	input wire logic [7:0] slot,
	output logic [3:0] stride_log2,
	output logic [TLBD_ADDR_W-1:0] addr
);

	logic [5:0] channel;
	logic [TLBD_ADDR_W-1:0] slot_offset;
	logic [TLBD_ADDR_W-1:0] chan_offset;

	// smallest power of two not below the fill count; scan from the top so the
	// lowest fitting exponent is the last one written
	always_comb begin
		stride_log2 = 4'h8;
		for (int n = 8; n >= 0; n--) begin
			if ((9'h001 << n) >= {1'b0, fill_bytes}) begin
				stride_log2 = 4'(n);
			end
		end
	end

	// station-then-component order, base address is station 0 component 0
	always_comb begin
		channel = 6'(station * 6'h03) + {4'h0, component};
		chan_offset = {18'h0_0000, channel} << stride_log2;
		slot_offset = {15'h0000, slot, 1'b0};
		addr = {ext, base[15:1], 1'b0} + chan_offset + slot_offset;
	end

endmodule

// File: rtl/tlbd_dma.sv
// Functional notes
// - capture strobe on swap or manual, when enabled
// - every memory write is one aligned word
// - base address bit zero always reads zero
// - fill count reads bytes per channel per buffer
// - channel stride is fill count rounded to power-of-two
// - upper byte reports top station; higher stations ignored
// - three channel buffers per station up to top
// - station zero component zero at base, then ascending
// - padding bytes past filled samples never written
// - external registers copied to working set at a swap with go set
// - buffer full set on completion, clear at start
module tlbd_dma
	import tlbd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	// reference pulses from the time source, asynchronous pins
	input wire logic pps_pin,
	input wire logic khz_pin,
	// configuration pins: time slots per buffer and top station code
	input wire logic [6:0] slots_pin,
	input wire logic [3:0] top_station_pin,
	// framed samples, same clock domain
	input wire logic sample_valid,
	input wire logic [3:0] sample_station,
	input wire logic [1:0] sample_component,
	input wire logic [15:0] sample_data,
	// register port, word or byte access
	input wire logic [1:0] reg_index,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] reg_be,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// memory write port
	output logic dma_req,
	output logic [TLBD_ADDR_W-1:0] dma_addr,
	output logic [TLBD_DATA_W-1:0] dma_data,
	input wire logic dma_ack,
	// time capture and swap request
	output logic time_capture_strobe,
	output logic swap_interrupt_request
);

	typedef struct packed {
		logic [1:0] pps_sync;
		logic pps_last;
		logic [1:0] khz_sync;
		logic khz_last;
		logic [6:0] slots_meta;
		logic [6:0] slots;
		logic [3:0] top_meta;
		logic [3:0] top;
		logic go;
		logic tcap_en;
		logic tcap_man;
		logic running;
		logic buffer_full_flag;
		logic overrun;
		logic swap_irq;
		logic [15:0] ext_base;
		logic [7:0] ext_ext;
		logic [15:0] work_base;
		logic [7:0] work_ext;
		logic [7:0] slot;
		tlbd_dma_e dma_state;
		logic [TLBD_ADDR_W-1:0] dma_addr;
		logic [TLBD_DATA_W-1:0] dma_data;
		logic tcap_strobe;
		logic [15:0] rdata;
	} tlbd_state_s;

	tlbd_state_s state;
	tlbd_state_s next_state;

	logic pps_edge;
	logic khz_edge;
	logic [7:0] fill_bytes;
	logic [3:0] stride_log2;
	logic [TLBD_ADDR_W-1:0] sample_addr;
	logic sample_ok;
	logic [15:0] ctl_word;
	logic [15:0] ext_top_word;
	logic wr_lo;
	logic wr_hi;

	////////////////////////////////////////////////////////////////////////////
	// address generation

	tlbd_addr_calc i_tlbd_addr_calc (
		.fill_bytes(fill_bytes),
		.base(state.work_base),
		.ext(state.work_ext),
		.station(sample_station),
		.component(sample_component),
		.slot(state.slot),
		.stride_log2(stride_log2),
		.addr(sample_addr)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	// edges look only at the second sync stage and its delayed copy
	assign pps_edge = state.pps_sync[1] & ~state.pps_last;
	assign khz_edge = state.khz_sync[1] & ~state.khz_last;
	assign fill_bytes = {state.slots, 1'b0};
	assign wr_lo = reg_wr & reg_be[0];
	assign wr_hi = reg_wr & reg_be[1];

	// out-of-range stations, the unused component code and slots past the fill
	// count are dropped, which also keeps the padding untouched
	assign sample_ok = state.running
		& (sample_station <= state.top)
		& (sample_component < TLBD_COMPONENTS)
		& (state.slot < {1'b0, state.slots});

	always_comb begin
		ctl_word = TLBD_RST_WORD;
		ctl_word[TLBD_CTL_GO] = state.go;
		ctl_word[TLBD_CTL_TCAP_EN] = state.tcap_en;
		ctl_word[TLBD_CTL_TCAP_MAN] = state.tcap_man;
		ctl_word[TLBD_CTL_RUNNING] = state.running;
		ctl_word[TLBD_CTL_BUF_FULL] = state.buffer_full_flag;
		ctl_word[TLBD_CTL_OVERRUN] = state.overrun;
		ctl_word[TLBD_CTL_SWAP_IRQ] = state.swap_irq;
		ext_top_word = TLBD_RST_WORD;
		ext_top_word[TLBD_EXT_LSB +: 8] = state.ext_ext;
		ext_top_word[TLBD_TOP_LSB +: 4] = state.top;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;

		// pins pass two flip-flops before anything reads them
		next_state.pps_sync = {state.pps_sync[0], pps_pin};
		next_state.pps_last = state.pps_sync[1];
		next_state.khz_sync = {state.khz_sync[0], khz_pin};
		next_state.khz_last = state.khz_sync[1];
		next_state.slots_meta = slots_pin;
		next_state.slots = state.slots_meta;
		next_state.top_meta = top_station_pin;
		next_state.top = state.top_meta;

		// register writes; byte lanes honoured so byte access works
		next_state.tcap_strobe = 1'b0;
		if (wr_lo) begin
			unique case (reg_index)
				TLBD_IDX_CONTROL: begin
					next_state.go = reg_wdata[TLBD_CTL_GO];
					next_state.tcap_en = reg_wdata[TLBD_CTL_TCAP_EN];
					next_state.tcap_man = reg_wdata[TLBD_CTL_TCAP_MAN];
					// flags clear by writing zero, as a bit-clear does
					if (!reg_wdata[TLBD_CTL_OVERRUN]) begin
						next_state.overrun = 1'b0;
					end
					if (!reg_wdata[TLBD_CTL_SWAP_IRQ]) begin
						next_state.swap_irq = 1'b0;
					end
				end
				TLBD_IDX_BASE: next_state.ext_base[7:0] = {reg_wdata[7:1], 1'b0};
				TLBD_IDX_EXT_TOP: next_state.ext_ext = reg_wdata[7:0];
				TLBD_IDX_FILL: ;
			endcase
		end
		if (wr_hi && reg_index == TLBD_IDX_BASE) begin
			next_state.ext_base[15:8] = reg_wdata[15:8];
		end

		// manual capture is a one-shot request that clears itself
		if (next_state.tcap_man) begin
			next_state.tcap_man = 1'b0;
			next_state.tcap_strobe = next_state.tcap_en;
		end

		// time slot advance; saturates so late slots land nowhere
		if (khz_edge && state.running && state.slot < {1'b0, state.slots}) begin
			next_state.slot = state.slot + 8'h01;
		end

		// buffer swap: flags set here win over a same-cycle software clear
		if (pps_edge) begin
			next_state.tcap_strobe = next_state.tcap_en;
			next_state.slot = TLBD_RST_SLOT;
			if (state.running || state.go) begin
				next_state.swap_irq = 1'b1;
				next_state.buffer_full_flag = state.running;
			end
			if (state.go) begin
				// go is consumed so an unreloaded set is never reused
				next_state.work_base = state.ext_base;
				next_state.work_ext = state.ext_ext;
				next_state.running = 1'b1;
				next_state.go = 1'b0;
			end else begin
				next_state.running = 1'b0;
			end
		end

		// one outstanding word; a sample while busy and not acked is an overrun and stops
		unique case (state.dma_state)
			TLBD_DMA_IDLE: begin
				if (sample_valid && sample_ok) begin
					next_state.dma_addr = sample_addr;
					next_state.dma_data = sample_data;
					next_state.dma_state = TLBD_DMA_BUSY;
				end
			end
			TLBD_DMA_BUSY: begin
				if (dma_ack) begin
					next_state.dma_state = TLBD_DMA_IDLE;
				end
				if (sample_valid && sample_ok && !dma_ack) begin
					next_state.overrun = 1'b1;
					next_state.running = 1'b0;
					next_state.go = 1'b0;
				end
			end
		endcase

		// read data is registered; unused upper lines read as zero
		if (reg_rd) begin
			unique case (reg_index)
				TLBD_IDX_CONTROL: next_state.rdata = ctl_word;
				TLBD_IDX_BASE: next_state.rdata = state.ext_base;
				TLBD_IDX_EXT_TOP: next_state.rdata = ext_top_word;
				TLBD_IDX_FILL: next_state.rdata = {8'h00, fill_bytes};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata = state.rdata;
	assign dma_req = (state.dma_state == TLBD_DMA_BUSY);
	assign dma_addr = state.dma_addr;
	assign dma_data = state.dma_data;
	assign time_capture_strobe = state.tcap_strobe;
	assign swap_interrupt_request = state.swap_irq;

endmodule

// File: tb/tlbd_dma_sva.sv
module tlbd_dma_chk
	import tlbd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] slots_pin,
	input wire logic [3:0] top_station_pin,
	input wire logic sample_valid,
	input wire logic [3:0] sample_station,
	input wire logic [1:0] sample_component,
	input wire logic [15:0] sample_data,
	input wire logic [1:0] reg_index,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic dma_req,
	input wire logic [TLBD_ADDR_W-1:0] dma_addr,
	input wire logic [TLBD_DATA_W-1:0] dma_data,
	input wire logic dma_ack,
	input wire logic time_capture_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////
	// memory side: one aligned word, held until taken
	word_even_a: assert property (dma_req |-> !dma_addr[0])
	else $error("odd word address");
	req_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
	else $error("request changed before ack");
	req_cause_a: assert property ($rose(dma_req) |-> $past(sample_valid)
		&& dma_data == $past(sample_data)) else $error("word without its sample");
	station_drop_a: assert property (sample_valid && !dma_req
		&& sample_station > top_station_pin |=> !dma_req) else $error("high station taken");
	comp_drop_a: assert property (sample_valid && !dma_req
		&& sample_component == 2'h3 |=> !dma_req) else $error("fourth component taken");
	// strobe and register reads
	strobe_pulse_a: assert property (time_capture_strobe |=> !time_capture_strobe)
	else $error("capture strobe too long");
	fill_read_a: assert property (reg_rd && reg_index == TLBD_IDX_FILL |=>
		reg_rdata == {8'h00, slots_pin, 1'b0}) else $error("fill count wrong");
	base_even_a: assert property (reg_rd && reg_index == TLBD_IDX_BASE |=> !reg_rdata[0])
	else $error("odd base read");
endmodule
bind tlbd_dma tlbd_dma_chk i_tlbd_dma_chk (.clk, .reset, .slots_pin, .top_station_pin,
	.sample_valid, .sample_station, .sample_component, .sample_data, .reg_index, .reg_rd,
	.reg_rdata, .dma_req, .dma_addr, .dma_data, .dma_ack, .time_capture_strobe);

// File: tb/tlbd_mem_model.sv
module tlbd_mem_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic dma_req,
	output logic dma_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt = 0;
	// one ack per word; the slow mode makes the block hold its request
	always @(posedge clk) begin
		dma_ack <= 1'b0;
		if (reset || !dma_req || dma_ack) begin
			wait_cnt <= 0;
		end else if (wait_cnt >= (slow ? 6 : 1)) begin
			dma_ack <= 1'b1;
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// File: tb/testbench.sv
module testbench
	import tlbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOTS = 5;
	localparam int TOP = 2;
	logic clk = 1'b0, reset = 1'b1, pps_pin = 1'b0, khz_pin = 1'b0, slow = 1'b0;
	logic sample_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [3:0] sample_station = 4'h0;
	logic [1:0] sample_component = 2'h0, reg_index = 2'h0, reg_be = 2'h0;
	logic [15:0] sample_data = 16'h0000, reg_wdata = 16'h0000, reg_rdata, dma_data;
	logic dma_req, dma_ack, time_capture_strobe, swap_interrupt_request;
	logic [23:0] dma_addr;
	int fails = 0, num_checks = 0, strobes = 0, seed = 93517;
	logic [39:0] dq[$];
	logic [15:0] rq[$];
	tlbd_dma i_tlbd_dma (.clk, .reset, .pps_pin, .khz_pin, .slots_pin(7'(SLOTS)),
		.top_station_pin(4'(TOP)), .sample_valid, .sample_station, .sample_component,
		.sample_data, .reg_index, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata,
		.dma_req, .dma_addr, .dma_data, .dma_ack, .time_capture_strobe, .swap_interrupt_request);
	tlbd_mem_model i_tlbd_mem_model (.clk, .reset, .slow, .dma_req, .dma_ack);
	always #(TLBD_CLK_PERIOD_NS / 2) clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic reg_op(input bit rd, input logic [1:0] idx, input logic [15:0] data);
		if (rd) begin
			rq.push_back(data);
		end
		@(posedge clk);
		reg_index <= idx;
		reg_be <= 2'h3;
		reg_wdata <= data;
		reg_rd <= rd;
		reg_wr <= !rd;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
	endtask
	task automatic pulse(input bit khz);
		@(posedge clk);
		khz_pin <= khz;
		pps_pin <= !khz;
		repeat (4) @(posedge clk);
		khz_pin <= 1'b0;
		pps_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// the channel stride is the fill count rounded up to a power of two
	function automatic int stride();
		int s = 1;
		while (s < 2 * SLOTS) begin
			s = s * 2;
		end
		return s;
	endfunction
	task automatic send(input int st, input int comp, input int slot, input bit take);
		logic [15:0] d;
		int n;
		d = 16'($random(seed));
		if (take) begin
			dq.push_back({24'h001234 + 24'((st * 3 + comp) * stride() + 2 * slot), d});
		end
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_station <= 4'(st);
		sample_component <= 2'(comp);
		sample_data <= d;
		@(posedge clk);
		sample_valid <= 1'b0;
		// the request rises only after this edge, so look once it has settled
		@(negedge clk);
		for (n = 0; n < 40 && dma_req !== 1'b0; n++) begin
			@(negedge clk);
		end
		if (n == 40) begin
			fails++;
			finish_test();
		end
	endtask
	////////////////////////////////////////////////////////////
	// take the oldest note whenever a word or a read result shows up
	always @(posedge clk) begin
		rd_d <= reg_rd;
		strobes <= strobes + int'(time_capture_strobe === 1'b1);
		if (dma_req === 1'b1 && dma_ack === 1'b1) begin
			check("dma word", dq.size() ? dq.pop_front() : 40'hx, {dma_addr, dma_data});
		end
		if (rd_d) begin
			check("register", rq.size() ? rq.pop_front() : 16'hx, reg_rdata);
		end
	end
	// main sequence; both lanes written, so base takes the whole word
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		reg_op(1'b0, TLBD_IDX_BASE, 16'h0035);
		reg_op(1'b1, TLBD_IDX_BASE, 16'h0034);
		reg_op(1'b0, TLBD_IDX_BASE, 16'h1234);
		reg_op(1'b1, TLBD_IDX_BASE, 16'h1234);
		reg_op(1'b1, TLBD_IDX_EXT_TOP, 16'(TOP << 8));
		reg_op(1'b0, TLBD_IDX_FILL, 16'h00ff);
		reg_op(1'b1, TLBD_IDX_FILL, 16'(2 * SLOTS));
		$display("test registers done");
		reg_op(1'b0, TLBD_IDX_CONTROL, 16'h0003);
		pulse(1'b0);
		check("swap request", 40'd1, 40'(swap_interrupt_request));
		reg_op(1'b1, TLBD_IDX_CONTROL, 16'h004a);
		for (int i = 0; i < 16; i++) begin
			slow <= i[0];
			send(i / 4, i % 4, 0, i / 4 <= TOP && i % 4 < 3);
		end
		$display("test layout done");
		for (int s = 1; s <= SLOTS; s++) begin
			pulse(1'b1);
			send(1, 1, s, s < SLOTS);
		end
		$display("test slots done");
		pulse(1'b0);
		reg_op(1'b1, TLBD_IDX_CONTROL, 16'h0052);
		send(0, 0, 0, 1'b0);
		reg_op(1'b0, TLBD_IDX_CONTROL, 16'h0004);
		reg_op(1'b0, TLBD_IDX_CONTROL, 16'h0006);
		repeat (4) @(posedge clk);
		check("capture strobes", 40'd3, 40'(strobes));
		check("swap cleared", 40'd0, 40'(swap_interrupt_request));
		check("pending words", 40'd0, 40'(dq.size()));
		$display("test capture done");
		finish_test();
	end
endmodule
